// >>> src/laboe_exec.sv
`timescale 1ns/1ps
module laboe_exec #(
    parameter logic [laboe_pkg::ADDR_W-1:0] TIMER_ADDR = laboe_pkg::TIMER_ADDR_DEF
) (
    input  wire logic                           CLOCK_I,
    input  wire logic                           RST_N_I,
    input  wire logic                           INSTR_VALID_I,
    input  wire logic [laboe_pkg::INSTR_W-1:0]  INSTR_I,
    input  wire logic [laboe_pkg::DATA_W-1:0]   FILE_RDATA_I,
    input  wire logic                           FILE_IS_PORT_I,
    input  wire logic [laboe_pkg::DATA_W-1:0]   PIN_LEVEL_I,
    input  wire logic                           PRESCALER_TO_TIMER_I,
    output logic [laboe_pkg::DATA_W-1:0]        ACCUM_O,
    output laboe_pkg::laboe_flags_type          FLAGS_O,
    output laboe_pkg::laboe_wr_type             FILE_WR_O,
    output logic                                SKIP_O,
    output logic                                PRESCALER_CLR_O
);
    // Registers
    logic [laboe_pkg::DATA_W-1:0] accum_q, accum_d;
    laboe_pkg::laboe_flags_type   flags_q, flags_d;
    laboe_pkg::laboe_wr_type      wr_q, wr_d;
    laboe_pkg::laboe_state_type   state_q, state_d;
    logic                         skip_q, skip_d;
    logic                         pclr_q, pclr_d;
    logic [laboe_pkg::DATA_W-1:0] pin_meta_q, pin_sync_q;

    // Instruction fields
    logic [1:0]                   cls;
    logic [3:0]                   byte_op;
    logic [1:0]                   bit_sel;
    logic [2:0]                   lit_op3;
    logic [3:0]                   lit_op4;
    logic                         dest;
    logic [laboe_pkg::BIT_W-1:0]  bit_idx;
    logic [laboe_pkg::ADDR_W-1:0] f_addr;
    logic [laboe_pkg::DATA_W-1:0] literal;
    laboe_pkg::laboe_op_type      op;

    // Datapath nets
    logic                         fwd_hit;
    logic [laboe_pkg::DATA_W-1:0] src;
    logic [laboe_pkg::DATA_W-1:0] operand_b;
    logic [laboe_pkg::DATA_W-1:0] and_res;
    logic [laboe_pkg::DATA_W-1:0] mask;
    logic [laboe_pkg::DATA_W-1:0] set_res;
    logic [laboe_pkg::DATA_W-1:0] clr_res;
    logic                         bit_val;
    logic                         is_lit;
    laboe_pkg::laboe_sum_type     add_res;

    // Field extraction
    assign cls     = INSTR_I[laboe_pkg::CLS_HI:laboe_pkg::CLS_LO];
    assign byte_op = INSTR_I[laboe_pkg::BYTE_OP_HI:laboe_pkg::BYTE_OP_LO];
    assign bit_sel = INSTR_I[laboe_pkg::BIT_SEL_HI:laboe_pkg::BIT_SEL_LO];       // [RL12]
    assign bit_idx = INSTR_I[laboe_pkg::BIT_IDX_HI:laboe_pkg::BIT_IDX_LO];       // [RL12]
    assign f_addr  = INSTR_I[laboe_pkg::ADDR_HI:0];
    assign lit_op3 = INSTR_I[laboe_pkg::LIT3_HI:laboe_pkg::LIT3_LO];
    assign lit_op4 = INSTR_I[laboe_pkg::LIT4_HI:laboe_pkg::LIT4_LO];
    assign dest    = INSTR_I[laboe_pkg::DEST_POS];
    assign literal = INSTR_I[laboe_pkg::LIT_HI:0];

    // Opcode decode; anything outside this group is left to the rest of the core
    assign op =
        (!INSTR_VALID_I) ? laboe_pkg::OP_NONE :
        (cls == laboe_pkg::CLASS_LIT && lit_op3 == laboe_pkg::LIT_ADD3) ?
            laboe_pkg::OP_ADD_IMMEDIATE_TO_ACCUMULATOR :
        (cls == laboe_pkg::CLASS_LIT && lit_op4 == laboe_pkg::LIT_AND4) ?
            laboe_pkg::OP_AND_IMMEDIATE_TO_ACCUMULATOR :
        (cls == laboe_pkg::CLASS_BYTE && byte_op == laboe_pkg::BYTE_ADD) ?
            laboe_pkg::OP_ADD_ACCUMULATOR_REGISTER :
        (cls == laboe_pkg::CLASS_BYTE && byte_op == laboe_pkg::BYTE_AND) ?
            laboe_pkg::OP_AND_ACCUMULATOR_REGISTER :
        (cls == laboe_pkg::CLASS_BIT && bit_sel == laboe_pkg::BSEL_CLR) ?
            laboe_pkg::OP_SINGLE_BIT_CLEAR :                                     // [RL12]
        (cls == laboe_pkg::CLASS_BIT && bit_sel == laboe_pkg::BSEL_SET) ?
            laboe_pkg::OP_SINGLE_BIT_FORCE_ONE :                                 // [RL12]
        (cls == laboe_pkg::CLASS_BIT && bit_sel == laboe_pkg::BSEL_TSTZ) ?
            laboe_pkg::OP_TEST_BIT_SKIP_ON_ZERO :                                // [RL12]
        (cls == laboe_pkg::CLASS_BIT && bit_sel == laboe_pkg::BSEL_TSTO) ?
            laboe_pkg::OP_TEST_BIT_SKIP_ON_ONE :                                 // [RL12]
        laboe_pkg::OP_NONE;

    // File operand: pins for ports, forwarded write for a just-written address,
    // else the register file read data. Forwarding keeps back-to-back results exact.
    assign fwd_hit = wr_q.we && (wr_q.addr == f_addr);                           // [RL14]
    assign src     = FILE_IS_PORT_I ? pin_sync_q :                               // [RL11]
                     fwd_hit        ? wr_q.data  : FILE_RDATA_I;
    assign is_lit  = (op == laboe_pkg::OP_ADD_IMMEDIATE_TO_ACCUMULATOR) ||
                     (op == laboe_pkg::OP_AND_IMMEDIATE_TO_ACCUMULATOR);
    assign operand_b = is_lit ? literal : src;

    // Logic results
    assign and_res = accum_q & operand_b;
    assign mask    = laboe_pkg::BIT_ONE << bit_idx;
    assign set_res = src | mask;                                                 // [RL7]
    assign clr_res = src & ~mask;                                                // [RL6]
    assign bit_val = src[bit_idx];

    laboe_add #(
        .NIB (laboe_pkg::NIB_W)
    ) u_add (
        .a_i   (accum_q),
        .b_i   (operand_b),
        .res_o (add_res)
    );

    // Next-state logic; squash state eats exactly one valid instruction
    always_comb begin
        accum_d   = accum_q;
        flags_d   = flags_q;
        wr_d      = wr_q;
        wr_d.we   = 1'b0;
        state_d   = state_q;
        skip_d    = 1'b0;
        pclr_d    = 1'b0;
        case (state_q)
            laboe_pkg::ST_SQUASH: begin
                if (INSTR_VALID_I) begin
                    state_d = laboe_pkg::ST_EXEC;                                // [RL8] [RL9]
                end
            end
            default: begin
                case (op)
                    laboe_pkg::OP_ADD_IMMEDIATE_TO_ACCUMULATOR: begin
                        accum_d                     = add_res.sum;               // [RL1]
                        flags_d.carry               = add_res.carry;             // [RL1]
                        flags_d.nibble_overflow_bit = add_res.nibble;            // [RL1]
                        flags_d.zero = (add_res.sum == laboe_pkg::DATA_ZERO);    // [RL13]
                    end
                    laboe_pkg::OP_AND_IMMEDIATE_TO_ACCUMULATOR: begin
                        accum_d      = and_res;                                  // [RL4]
                        flags_d.zero = (and_res == laboe_pkg::DATA_ZERO);        // [RL4]
                    end
                    laboe_pkg::OP_ADD_ACCUMULATOR_REGISTER: begin
                        flags_d.carry               = add_res.carry;             // [RL2]
                        flags_d.nibble_overflow_bit = add_res.nibble;            // [RL2]
                        flags_d.zero = (add_res.sum == laboe_pkg::DATA_ZERO);    // [RL2]
                        if (dest == laboe_pkg::DEST_FILE) begin
                            wr_d = '{we: 1'b1, addr: f_addr, data: add_res.sum}; // [RL3]
                        end else begin
                            accum_d = add_res.sum;                               // [RL3]
                        end
                    end
                    laboe_pkg::OP_AND_ACCUMULATOR_REGISTER: begin
                        flags_d.zero = (and_res == laboe_pkg::DATA_ZERO);        // [RL5]
                        if (dest == laboe_pkg::DEST_FILE) begin
                            wr_d = '{we: 1'b1, addr: f_addr, data: and_res};     // [RL3]
                        end else begin
                            accum_d = and_res;                                   // [RL3]
                        end
                    end
                    laboe_pkg::OP_SINGLE_BIT_CLEAR: begin
                        wr_d = '{we: 1'b1, addr: f_addr, data: clr_res};         // [RL6]
                    end
                    laboe_pkg::OP_SINGLE_BIT_FORCE_ONE: begin
                        wr_d = '{we: 1'b1, addr: f_addr, data: set_res};         // [RL7]
                    end
                    laboe_pkg::OP_TEST_BIT_SKIP_ON_ZERO: begin
                        if (!bit_val) begin
                            skip_d  = 1'b1;                                      // [RL8]
                            state_d = laboe_pkg::ST_SQUASH;                      // [RL8]
                        end
                    end
                    laboe_pkg::OP_TEST_BIT_SKIP_ON_ONE: begin
                        if (bit_val) begin
                            skip_d  = 1'b1;                                      // [RL9]
                            state_d = laboe_pkg::ST_SQUASH;                      // [RL9]
                        end
                    end
                    default: begin
                        accum_d = accum_q;
                    end
                endcase
                // A write into the timer count restarts the prescaler only when the prescaler belongs to the timer
                if (wr_d.we && (f_addr == TIMER_ADDR) && PRESCALER_TO_TIMER_I) begin
                    pclr_d = 1'b1;                                               // [RL10]
                end
            end
        endcase
    end

    // Pin levels come from outside the clock domain; only the second stage is read
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_meta_q <= laboe_pkg::DATA_ZERO;
            pin_sync_q <= laboe_pkg::DATA_ZERO;
        end else begin
            pin_meta_q <= PIN_LEVEL_I;
            pin_sync_q <= pin_meta_q;                                            // [RL11]
        end
    end

    // Architectural state and output flops
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            accum_q <= laboe_pkg::ACCUM_RST;
            flags_q <= laboe_pkg::FLAGS_RST;
            wr_q    <= laboe_pkg::WR_RST;
            state_q <= laboe_pkg::ST_EXEC;
            skip_q  <= 1'b0;
            pclr_q  <= 1'b0;
        end else begin
            accum_q <= accum_d;                                                  // [RL14]
            flags_q <= flags_d;
            wr_q    <= wr_d;
            state_q <= state_d;
            skip_q  <= skip_d;
            pclr_q  <= pclr_d;
        end
    end

    assign ACCUM_O         = accum_q;
    assign FLAGS_O         = flags_q;
    assign FILE_WR_O       = wr_q;
    assign SKIP_O          = skip_q;
    assign PRESCALER_CLR_O = pclr_q;

endmodule : laboe_exec

// >>> src/laboe_pkg.sv
// How it works
// RL1: Immediate add sums accumulator and 8-bit literal into accumulator, updates carry, nibble, zero.
// RL2: Register add sums accumulator and addressed file register, updates carry, nibble, zero.
// RL3: Register add and AND write accumulator on destination 0, file register on 1.
// RL4: Immediate AND masks accumulator with literal into accumulator, zero flag only.
// RL5: Register AND masks accumulator with file register, only zero flag changes.
// RL6: Bit clear forces selected bit of file register low, nothing else changes.
// RL7: Bit set forces selected bit of file register high, nothing else changes.
// RL8: Skip-on-zero test discards next instruction when bit is zero, two cycles.
// RL9: Skip-on-one test discards next instruction when bit is one, two cycles.
// RL10: Writing timer zero count clears prescaler when prescaler belongs to timer.
// RL11: Port registers modified from themselves take source from pin levels.
// RL12: Bit ops decode as prefix 01, two-bit selector, bit index, file address.
// RL13: Zero on zero result, carry out of bit 7, nibble carry out of bit 3.
// RL14: Each non-skipping instruction completes in one cycle, visible to the next.
package laboe_pkg;

    // Widths
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 7;
    localparam int INSTR_W = 14;
    localparam int BIT_W   = 3;
    localparam int NIB_W   = 4;

    // Instruction field positions
    localparam int CLS_HI     = 13;
    localparam int CLS_LO     = 12;
    localparam int BYTE_OP_HI = 11;
    localparam int BYTE_OP_LO = 8;
    localparam int DEST_POS   = 7;
    localparam int BIT_SEL_HI = 11;
    localparam int BIT_SEL_LO = 10;
    localparam int BIT_IDX_HI = 9;
    localparam int BIT_IDX_LO = 7;
    localparam int ADDR_HI    = 6;
    localparam int LIT_HI     = 7;
    localparam int LIT3_HI    = 11;
    localparam int LIT3_LO    = 9;
    localparam int LIT4_HI    = 11;
    localparam int LIT4_LO    = 8;

    // Opcode values
    localparam logic [1:0] CLASS_BYTE = 2'h0;
    localparam logic [1:0] CLASS_BIT  = 2'h1;
    localparam logic [1:0] CLASS_LIT  = 2'h3;
    localparam logic [3:0] BYTE_ADD   = 4'h7;
    localparam logic [3:0] BYTE_AND   = 4'h5;
    localparam logic [2:0] LIT_ADD3   = 3'h7;
    localparam logic [3:0] LIT_AND4   = 4'h9;
    localparam logic [1:0] BSEL_CLR   = 2'h0;
    localparam logic [1:0] BSEL_SET   = 2'h1;
    localparam logic [1:0] BSEL_TSTZ  = 2'h2;
    localparam logic [1:0] BSEL_TSTO  = 2'h3;
    localparam logic       DEST_FILE  = 1'h1;

    // Reset values and defaults
    localparam logic [DATA_W-1:0] ACCUM_RST      = 8'h00;
    localparam logic [ADDR_W-1:0] TIMER_ADDR_DEF = 7'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO      = 8'h00;
    localparam logic [DATA_W-1:0] BIT_ONE        = 8'h01;

    typedef struct packed {
        logic carry;
        logic nibble_overflow_bit;
        logic zero;
    } laboe_flags_type;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } laboe_wr_type;

    typedef struct packed {
        logic [DATA_W-1:0] sum;
        logic              carry;
        logic              nibble;
    } laboe_sum_type;

    localparam laboe_flags_type FLAGS_RST = '{carry: 1'h0, nibble_overflow_bit: 1'h0, zero: 1'h0};
    localparam laboe_wr_type    WR_RST    = '{we: 1'h0, addr: 7'h00, data: 8'h00};

    typedef enum logic [0:0] {
        ST_EXEC   = 1'b0,
        ST_SQUASH = 1'b1
    } laboe_state_type;

    typedef enum logic [3:0] {
        OP_NONE                         = 4'b0000,
        OP_ADD_IMMEDIATE_TO_ACCUMULATOR = 4'b0001,
        OP_AND_IMMEDIATE_TO_ACCUMULATOR = 4'b0010,
        OP_ADD_ACCUMULATOR_REGISTER     = 4'b0011,
        OP_AND_ACCUMULATOR_REGISTER     = 4'b0100,
        OP_SINGLE_BIT_CLEAR             = 4'b0101,
        OP_SINGLE_BIT_FORCE_ONE         = 4'b0110,
        OP_TEST_BIT_SKIP_ON_ZERO        = 4'b0111,
        OP_TEST_BIT_SKIP_ON_ONE         = 4'b1000
    } laboe_op_type;

endpackage : laboe_pkg

// >>> src/laboe_add.sv
`timescale 1ns/1ps
// Adder with carry out of the top bit and out of the low nibble
module laboe_add #(
    parameter int NIB = laboe_pkg::NIB_W
) (
    input  wire logic [laboe_pkg::DATA_W-1:0] a_i,
    input  wire logic [laboe_pkg::DATA_W-1:0] b_i,
    output laboe_pkg::laboe_sum_type          res_o
);
    logic [laboe_pkg::DATA_W:0] full_sum;
    logic [NIB:0]               nib_sum;

    // Separate nibble sum gives the digit carry without tapping the main carry chain
    assign full_sum     = {1'b0, a_i} + {1'b0, b_i};
    assign nib_sum      = {1'b0, a_i[NIB-1:0]} + {1'b0, b_i[NIB-1:0]};
    assign res_o.sum    = full_sum[laboe_pkg::DATA_W-1:0];
    assign res_o.carry  = full_sum[laboe_pkg::DATA_W];   // [RL13]
    assign res_o.nibble = nib_sum[NIB];                  // [RL13]

endmodule : laboe_add

// >>> verification/laboe_exec_chk.sv
`timescale 1ns/1ps
// Port-level checks on the execute block
module laboe_exec_chk #(
    parameter logic [laboe_pkg::ADDR_W-1:0] TIMER_ADDR = laboe_pkg::TIMER_ADDR_DEF
) (
    input wire logic                          CLOCK_I,
    input wire logic                          RST_N_I,
    input wire logic                          INSTR_VALID_I,
    input wire logic [laboe_pkg::INSTR_W-1:0] INSTR_I,
    input wire logic [laboe_pkg::DATA_W-1:0]  FILE_RDATA_I,
    input wire logic                          FILE_IS_PORT_I,
    input wire logic [laboe_pkg::DATA_W-1:0]  PIN_LEVEL_I,
    input wire logic                          PRESCALER_TO_TIMER_I,
    input wire logic [laboe_pkg::DATA_W-1:0]  ACCUM_O,
    input wire laboe_pkg::laboe_flags_type    FLAGS_O,
    input wire laboe_pkg::laboe_wr_type       FILE_WR_O,
    input wire logic                          SKIP_O,
    input wire logic                          PRESCALER_CLR_O
);
    logic held_q;
    logic held_d;
    // A skip stays pending over idle cycles until a valid word is swallowed
    wire pend  = SKIP_O | held_q;
    wire live  = INSTR_VALID_I & ~pend;
    wire addi  = live & (INSTR_I[13:9] == 5'h1f);
    wire andi  = live & (INSTR_I[13:8] == 6'h39);
    wire regop = live & (INSTR_I[13:12] == 2'h0) & (INSTR_I[11:8] == 4'h7 | INSTR_I[11:8] == 4'h5);
    wire bitop = live & (INSTR_I[13:12] == 2'h1);
    wire wfile = (regop & INSTR_I[7]) | (bitop & ~INSTR_I[11]);
    assign held_d = pend & ~INSTR_VALID_I;
    // Mirror of the squash state, rebuilt from ports only
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            held_q <= 1'b0;
        end else begin
            held_q <= held_d;
        end
    end
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    chk_add_imm_sum: assert property (addi |=> {FLAGS_O.carry, ACCUM_O} ==
        9'($past(ACCUM_O)) + 9'($past(INSTR_I[7:0]))) else $error("immediate add wrong");
    chk_add_nibble_carry: assert property (addi |=> FLAGS_O.nibble_overflow_bit ==
        ((5'($past(ACCUM_O[3:0])) + 5'($past(INSTR_I[3:0]))) > 5'h0f)) else $error("nibble carry");
    chk_zero_flag: assert property ((addi | andi) |=> FLAGS_O.zero == (ACCUM_O == 8'h00))
        else $error("zero flag wrong");
    chk_and_imm_only: assert property (andi |=> ACCUM_O == ($past(ACCUM_O) & $past(INSTR_I[7:0]))
        && FLAGS_O[2:1] == $past(FLAGS_O[2:1])) else $error("immediate and wrong");
    chk_reg_dest: assert property (regop |=> FILE_WR_O.we == $past(INSTR_I[7]) &&
        (!FILE_WR_O.we || FILE_WR_O.addr == $past(INSTR_I[6:0]))) else $error("destination");
    chk_reg_keep_acc: assert property (regop && INSTR_I[7] |=> $stable(ACCUM_O))
        else $error("accumulator changed on file destination");
    chk_bit_write: assert property (bitop && !INSTR_I[11] |=> FILE_WR_O.we &&
        FILE_WR_O.data[$past(INSTR_I[9:7])] == $past(INSTR_I[10]) && $stable(FLAGS_O))
        else $error("bit write wrong");
    chk_bit_test_quiet: assert property (bitop && INSTR_I[11] |=> !FILE_WR_O.we &&
        !PRESCALER_CLR_O && $stable(ACCUM_O) && $stable(FLAGS_O)) else $error("bit test wrote");
    chk_squash_quiet: assert property (pend && INSTR_VALID_I |=> !FILE_WR_O.we && !SKIP_O &&
        $stable(ACCUM_O) && $stable(FLAGS_O)) else $error("discarded word acted");
    chk_presc_clear: assert property (wfile && INSTR_I[6:0] == TIMER_ADDR &&
        PRESCALER_TO_TIMER_I |=> PRESCALER_CLR_O) else $error("prescaler not cleared");
    // Only a real write into the timer count may restart the prescaler
    chk_presc_quiet: assert property (!(wfile && INSTR_I[6:0] == TIMER_ADDR &&
        PRESCALER_TO_TIMER_I) |=> !PRESCALER_CLR_O) else $error("stray prescaler clear");
    cov_add_imm: cover property (addi);
    cov_skip_swallow: cover property (SKIP_O ##1 INSTR_VALID_I);
    cov_presc: cover property (PRESCALER_CLR_O);
endmodule : laboe_exec_chk

bind laboe_exec laboe_exec_chk #(.TIMER_ADDR(TIMER_ADDR)) u_chk (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I),
    .FILE_RDATA_I(FILE_RDATA_I), .FILE_IS_PORT_I(FILE_IS_PORT_I), .PIN_LEVEL_I(PIN_LEVEL_I),
    .PRESCALER_TO_TIMER_I(PRESCALER_TO_TIMER_I), .ACCUM_O(ACCUM_O), .FLAGS_O(FLAGS_O),
    .FILE_WR_O(FILE_WR_O), .SKIP_O(SKIP_O), .PRESCALER_CLR_O(PRESCALER_CLR_O));

// >>> verification/laboe_fmodel.sv
`timescale 1ns/1ps
// File register space on the far side of the execute block
module laboe_fmodel (
    input  wire logic                         clock_i,
    input  wire logic [laboe_pkg::ADDR_W-1:0] addr_i,
    input  wire laboe_pkg::laboe_wr_type      wr_i,
    output logic [laboe_pkg::DATA_W-1:0]      rdata_o
);
    logic [laboe_pkg::DATA_W-1:0] mem [128];
    // Known fill, so the bench can predict every first read
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i) ^ 8'ha5;
        end
    end
    // Commit at the edge after the write shows; the block forwards meanwhile
    always @(posedge clock_i) begin
        if (wr_i.we) begin
            mem[wr_i.addr] <= wr_i.data;
        end
    end
    assign rdata_o = mem[addr_i];
endmodule : laboe_fmodel

// >>> verification/laboe_exec_tb.sv
`timescale 1ns/1ps
module laboe_exec_tb;
    logic                       clk, rst_n, valid, is_port, presc, skip, pclr;
    logic [13:0]                instr;
    logic [7:0]                 pins, rdata, accum;
    laboe_pkg::laboe_flags_type flags;
    laboe_pkg::laboe_wr_type    wr;
    int                         miscompares = 0;
    int                         n_compared = 0;
    int                         cycles = 0;

    laboe_exec u_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .INSTR_VALID_I(valid), .INSTR_I(instr),
        .FILE_RDATA_I(rdata), .FILE_IS_PORT_I(is_port), .PIN_LEVEL_I(pins),
        .PRESCALER_TO_TIMER_I(presc), .ACCUM_O(accum), .FLAGS_O(flags), .FILE_WR_O(wr),
        .SKIP_O(skip), .PRESCALER_CLR_O(pclr));
    laboe_fmodel u_fm (.clock_i(clk), .addr_i(instr[6:0]), .wr_i(wr), .rdata_o(rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is under a hundred cycles; a hang ends here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (miscompares == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Drive one word at the falling edge; return just after the taking edge
    task automatic issue(input logic [13:0] w, input logic v);
        @(negedge clk);
        valid = v;
        instr = w;
        @(posedge clk);
        #1;
    endtask : issue

    task automatic af(input logic [7:0] a, input logic [2:0] f);
        check({5'h00, flags, accum}, {5'h00, f, a});
    endtask : af

    task automatic t_imm();
        issue(14'h3e8f, 1'b1); af(8'h8f, 3'h0);
        issue(14'h3e71, 1'b1); af(8'h00, 3'h7);
        issue(14'h3ef8, 1'b1); af(8'hf8, 3'h0);
        issue(14'h3e18, 1'b1); af(8'h10, 3'h6);
        issue(14'h3910, 1'b1); af(8'h10, 3'h6);
        issue(14'h3901, 1'b1); af(8'h00, 3'h7);
        issue(14'h0000, 1'b0);
    endtask : t_imm

    // Register operands, both destinations, write to the timer address
    task automatic t_reg();
        @(negedge clk);
        presc = 1'b1;
        issue(14'h3e5c, 1'b1); af(8'h5c, 3'h0);
        issue(14'h0781, 1'b1); af(8'h5c, 3'h7);
        check(wr, 16'h8100);
        check({15'h0000, pclr}, 16'h0001);
        issue(14'h0582, 1'b1); af(8'h5c, 3'h6);
        check(wr, 16'h8204);
        check({15'h0000, pclr}, 16'h0000);
        issue(14'h0701, 1'b1); af(8'h5c, 3'h0);
        check({15'h0000, wr.we}, 16'h0000);
        check({15'h0000, pclr}, 16'h0000);
        issue(14'h0000, 1'b0);
    endtask : t_reg

    task automatic t_bits();
        issue(14'h1383, 1'b1); check(wr, 16'h8326);
        af(8'h5c, 3'h0);
        issue(14'h1403, 1'b1); check(wr, 16'h8327);
        issue(14'h1501, 1'b1); check(wr, 16'h8104);
        check({15'h0000, pclr}, 16'h0001);
        issue(14'h0000, 1'b0);
    endtask : t_bits

    // Skips taken and not taken, and an idle gap before the swallowed word
    task automatic t_skip();
        issue(14'h1983, 1'b1); check({wr.we, 14'h0000, skip}, 16'h0001);
        issue(14'h3e01, 1'b1); af(8'h5c, 3'h0);
        issue(14'h1803, 1'b1); check({15'h0000, skip}, 16'h0000);
        issue(14'h3e01, 1'b1); af(8'h5d, 3'h0);
        issue(14'h1c03, 1'b1); check({15'h0000, skip}, 16'h0001);
        issue(14'h0000, 1'b0);
        issue(14'h3e01, 1'b1); af(8'h5d, 3'h0);
        issue(14'h3e01, 1'b1); af(8'h5e, 3'h0);
        issue(14'h1f83, 1'b1); check({15'h0000, skip}, 16'h0000);
        issue(14'h0000, 1'b0);
    endtask : t_skip

    // Port operand must come from the pins, not the stored latch value
    task automatic t_port();
        @(negedge clk);
        is_port = 1'b1;
        pins = 8'hc3;
        issue(14'h0000, 1'b0);
        issue(14'h0000, 1'b0);
        issue(14'h0505, 1'b1); af(8'h42, 3'h0);
        issue(14'h0000, 1'b0);
    endtask : t_port

    initial begin
        rst_n = 1'b0;
        valid = 1'b0;
        instr = 14'h0000;
        is_port = 1'b0;
        presc = 1'b0;
        pins = 8'h00;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        #1;
        check(wr, 16'h0000);
        check({5'h00, flags, accum}, 16'h0000);
        check({14'h0000, skip, pclr}, 16'h0000);
        t_imm();
        t_reg();
        t_bits();
        t_skip();
        t_port();
        give_verdict();
    end
endmodule : laboe_exec_tb
